// ---- core/tbp_pwm.sv ----
// Dual ten-bit pulse-width modulator with shared 8-bit timer base.
// Assumes an APB master on i_clk and an external sleep level input.
//
// Overview of operation
// - Idle level follows polarity select.
// - Disabled channel drives its idle level.
// - Period is (period+1)*4*Tosc*prescale.
// - Count equal period clears on next increment.
// - Period start sets output unless duty zero.
// - Period start latches buffered duty value.
// - Duty beyond period never clears output.
// - Duty is 10 bits, left justified split.
// - Duty writes buffered, applied at period start.
// - Time base is count plus two sub bits.
// - Pulse width is duty*Tosc*prescale.
// - Resolution reaches ten bits at period 255.
// - Sleep freezes counting and outputs.
// - Reset clears enable and polarity.
// - Control: enable b7, level b5, polarity b4.
// - Output frequency follows the system clock.
// - Two identical channels share the timer.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module tbp_pwm
    import tbp_pkg::*;
#(
    parameter int CHANNELS = 2
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Power state.
    input wire logic i_sleep,
    // Modulator outputs and timer match flag.
    output logic [CHANNELS-1:0] o_pwm,
    output logic o_period_match
);

    // ==========================================================
    // Register bus decode.
    // ==========================================================
    logic wr_en;
    logic rd_en;
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_en = i_psel && i_penable && !i_pwrite;
    assign o_pready = 1'b1;

    logic [7:0] timer_control_reg;
    logic [7:0] period_register_reg;
    logic [7:0] base_timer_count_reg;
    logic [CHANNELS-1:0] module_on_reg;
    logic [CHANNELS-1:0] output_polarity_reg;
    logic [CHANNELS-1:0] active_reg;
    logic [9:0] duty_word_reg [CHANNELS];
    logic [9:0] duty_latch_reg [CHANNELS];

    logic timer_run;
    logic [1:0] timer_prescale_select;
    assign timer_run = timer_control_reg[TCTL_TIMER_RUN_BIT];
    assign timer_prescale_select = timer_control_reg[TCTL_PRESCALE_MSB -: 2];

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            timer_control_reg <= RST_TIMER_CONTROL;
            period_register_reg <= RST_PERIOD;
        end else if (wr_en && i_paddr == OFS_TIMER_CONTROL) begin
            timer_control_reg <= i_pwdata[7:0];
        end else if (wr_en && i_paddr == OFS_PERIOD) begin
            period_register_reg <= i_pwdata[7:0];
        end
    end

    // ==========================================================
    // Prescaler: oscillator cycles per timer increment.
    // ==========================================================
    // Prescale 1, 4, 16, 64 gives 4, 16, 64, 256 clocks per increment.
    logic [SUBCOUNT_W+1:0] sub_limit;
    always_comb begin
        case (timer_prescale_select)
            2'b00: sub_limit = 8'(OSC_PER_INCREMENT - 1);
            2'b01: sub_limit = 8'(OSC_PER_INCREMENT * 4 - 1);
            2'b10: sub_limit = 8'(OSC_PER_INCREMENT * 16 - 1);
            default: sub_limit = 8'(OSC_PER_INCREMENT * 64 - 1);
        endcase
    end

    logic [7:0] sub_full_reg;
    logic increment;
    logic counting;
    assign counting = timer_run && !i_sleep;
    assign increment = counting && (sub_full_reg == sub_limit);

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sub_full_reg <= 8'h00;
        end else if (counting) begin
            sub_full_reg <= increment ? 8'h00 : sub_full_reg + 8'h01;
        end
    end

    // ==========================================================
    // Shared 8-bit timer.
    // ==========================================================
    logic match;
    logic period_start;
    assign match = (base_timer_count_reg == period_register_reg);
    assign period_start = increment && match;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            base_timer_count_reg <= 8'h00;
        end else if (wr_en && i_paddr == OFS_TIMER_COUNT) begin
            base_timer_count_reg <= i_pwdata[7:0];
        end else if (period_start) begin
            base_timer_count_reg <= 8'h00;
        end else if (increment) begin
            base_timer_count_reg <= base_timer_count_reg + 8'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_period_match <= 1'b0;
        end else begin
            o_period_match <= period_start;
        end
    end

    // Two low time-base bits: clock phase at 1:1, prescaler top bits otherwise.
    logic [1:0] low_bits;
    always_comb begin
        case (timer_prescale_select)
            2'b00: low_bits = sub_full_reg[1:0];
            2'b01: low_bits = sub_full_reg[3:2];
            2'b10: low_bits = sub_full_reg[5:4];
            default: low_bits = sub_full_reg[7:6];
        endcase
    end

    logic [9:0] time_base;
    assign time_base = {base_timer_count_reg, low_bits};

    // Time base one clock ahead: the pulse ends exactly duty steps after the
    // period starts, so the registered output does not run one clock long.
    logic [7:0] sub_full_next;
    logic [7:0] count_step;
    logic [1:0] low_bits_next;
    logic [9:0] time_base_next;
    assign sub_full_next = increment ? 8'h00 : sub_full_reg + 8'h01;
    assign count_step = period_start ? 8'h00
        : (increment ? base_timer_count_reg + 8'h01 : base_timer_count_reg);
    always_comb begin
        case (timer_prescale_select)
            2'b00: low_bits_next = sub_full_next[1:0];
            2'b01: low_bits_next = sub_full_next[3:2];
            2'b10: low_bits_next = sub_full_next[5:4];
            default: low_bits_next = sub_full_next[7:6];
        endcase
    end
    assign time_base_next = {count_step, low_bits_next};

    // ==========================================================
    // Modulator channels.
    // ==========================================================
    logic [31:0] ch_rdata [CHANNELS];

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            localparam logic [7:0] CTL_A = 8'(OFS_MOD0_CONTROL + g * OFS_CHANNEL_STRIDE);
            localparam logic [7:0] DCH_A = 8'(OFS_MOD0_DUTY_HIGH + g * OFS_CHANNEL_STRIDE);
            localparam logic [7:0] DCL_A = 8'(OFS_MOD0_DUTY_LOW + g * OFS_CHANNEL_STRIDE);

            always_ff @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    module_on_reg[g] <= RST_CONTROL[CTL_MODULE_ON_BIT];
                    output_polarity_reg[g] <= RST_CONTROL[CTL_POLARITY_BIT];
                end else if (wr_en && i_paddr == CTL_A) begin
                    module_on_reg[g] <= i_pwdata[CTL_MODULE_ON_BIT];
                    output_polarity_reg[g] <= i_pwdata[CTL_POLARITY_BIT];
                end
            end

            // Buffered duty, split high byte and two left-justified low bits.
            always_ff @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    duty_word_reg[g] <= RST_DUTY;
                end else if (wr_en && i_paddr == DCH_A) begin
                    duty_word_reg[g][9:2] <= i_pwdata[7:0];
                end else if (wr_en && i_paddr == DCL_A) begin
                    duty_word_reg[g][1:0] <= i_pwdata[DUTY_LOW_MSB:DUTY_LOW_LSB];
                end
            end

            always_ff @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    duty_latch_reg[g] <= RST_DUTY;
                    active_reg[g] <= 1'b0;
                end else if (period_start) begin
                    duty_latch_reg[g] <= duty_word_reg[g];
                    active_reg[g] <= (duty_word_reg[g] != 10'h000);
                end else if (counting && time_base_next == duty_latch_reg[g]) begin
                    // A latch beyond the period is never reached.
                    active_reg[g] <= 1'b0;
                end
            end

            // Inactive level equals polarity; disabled channel shows it.
            always_ff @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    o_pwm[g] <= 1'b0;
                end else if (!i_sleep) begin
                    o_pwm[g] <= (module_on_reg[g] && active_reg[g]) ^ output_polarity_reg[g];
                end
            end

            always_comb begin
                ch_rdata[g] = 32'h0000_0000;
                if (i_paddr == CTL_A) begin
                    ch_rdata[g][CTL_MODULE_ON_BIT] = module_on_reg[g];
                    ch_rdata[g][CTL_LIVE_OUTPUT_BIT] = o_pwm[g];
                    ch_rdata[g][CTL_POLARITY_BIT] = output_polarity_reg[g];
                end else if (i_paddr == DCH_A) begin
                    ch_rdata[g][7:0] = duty_word_reg[g][9:2];
                end else if (i_paddr == DCL_A) begin
                    ch_rdata[g][DUTY_LOW_MSB:DUTY_LOW_LSB] = duty_word_reg[g][1:0];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read data and error response.
    // ==========================================================
    logic [31:0] rdata_next;
    logic hit;
    always_comb begin
        rdata_next = 32'h0000_0000;
        hit = (i_paddr == OFS_TIMER_CONTROL) || (i_paddr == OFS_PERIOD)
            || (i_paddr == OFS_TIMER_COUNT);
        case (i_paddr)
            OFS_TIMER_CONTROL: rdata_next[7:0] = timer_control_reg;
            OFS_PERIOD: rdata_next[7:0] = period_register_reg;
            OFS_TIMER_COUNT: rdata_next[7:0] = base_timer_count_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
        for (int c = 0; c < CHANNELS; c++) begin
            rdata_next = rdata_next | ch_rdata[c];
            if (i_paddr == 8'(OFS_MOD0_CONTROL + c * OFS_CHANNEL_STRIDE)
                || i_paddr == 8'(OFS_MOD0_DUTY_HIGH + c * OFS_CHANNEL_STRIDE)
                || i_paddr == 8'(OFS_MOD0_DUTY_LOW + c * OFS_CHANNEL_STRIDE)) begin
                hit = 1'b1;
            end
        end
    end

    // Read data is captured at the end of the setup cycle, so it stands
    // from a flop through the whole access cycle and is zero otherwise.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= rdata_next;
        end else begin
            o_prdata <= 32'h0000_0000;
        end
    end
    assign o_pslverr = i_psel && i_penable && !hit;

    // ==========================================================
    // Checks.
    // ==========================================================
    property p_wrap;
        @(posedge i_clk) disable iff (i_reset)
        (increment && match && !(wr_en && i_paddr == OFS_TIMER_COUNT))
            |=> base_timer_count_reg == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("timer did not clear at match");

    property p_latch;
        @(posedge i_clk) disable iff (i_reset)
        period_start |=> duty_latch_reg[0] == $past(duty_word_reg[0]);
    endproperty
    a_latch: assert property (p_latch) else $error("duty not latched at period");

    property p_zero;
        @(posedge i_clk) disable iff (i_reset)
        (period_start && duty_word_reg[0] == 10'h000) |=> !active_reg[0];
    endproperty
    a_zero: assert property (p_zero) else $error("zero duty set output");

    property p_set;
        @(posedge i_clk) disable iff (i_reset)
        (period_start && duty_word_reg[0] != 10'h000) |=> active_reg[0];
    endproperty
    a_set: assert property (p_set) else $error("output not set at period");

    property p_idle;
        @(posedge i_clk) disable iff (i_reset)
        (!module_on_reg[0] && !i_sleep) |=> o_pwm[0] == $past(output_polarity_reg[0]);
    endproperty
    a_idle: assert property (p_idle) else $error("disabled output not idle");

    property p_sleep;
        @(posedge i_clk) disable iff (i_reset)
        (i_sleep && !(wr_en && i_paddr == OFS_TIMER_COUNT)) |=> $stable(base_timer_count_reg) && $stable(o_pwm);
    endproperty
    a_sleep: assert property (p_sleep) else $error("state moved in sleep");

    property p_clear;
        @(posedge i_clk) disable iff (i_reset)
        (counting && !period_start && time_base_next == duty_latch_reg[0]) |=> !active_reg[0];
    endproperty
    a_clear: assert property (p_clear) else $error("output not cleared at duty");

    property p_stepgap;
        @(posedge i_clk) disable iff (i_reset)
        (increment && timer_prescale_select == 2'b00) |=> !increment [*3];
    endproperty
    a_stepgap: assert property (p_stepgap) else $error("increment faster than four clocks");

    property p_level;
        @(posedge i_clk) disable iff (i_reset)
        (rd_en && i_paddr == OFS_MOD0_CONTROL)
            |-> o_prdata[CTL_LIVE_OUTPUT_BIT] == $past(o_pwm[0]);
    endproperty
    a_level: assert property (p_level) else $error("live level readback wrong");

    property p_lookahead;
        @(posedge i_clk) disable iff (i_reset)
        (counting && !(wr_en && (i_paddr == OFS_TIMER_COUNT
            || i_paddr == OFS_TIMER_CONTROL))) |=> time_base == $past(time_base_next);
    endproperty
    a_lookahead: assert property (p_lookahead) else $error("time base step wrong");

    property p_count_step;
        @(posedge i_clk) disable iff (i_reset)
        (increment && !match && !(wr_en && i_paddr == OFS_TIMER_COUNT))
            |=> base_timer_count_reg == $past(base_timer_count_reg) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("timer did not step");

    property p_match_out;
        @(posedge i_clk) disable iff (i_reset)
        1'b1 |=> o_period_match == $past(period_start);
    endproperty
    a_match_out: assert property (p_match_out) else $error("match pulse misplaced");

    property p_beyond;
        @(posedge i_clk) disable iff (i_reset)
        (active_reg[0] && !period_start && base_timer_count_reg <= period_register_reg
            && duty_latch_reg[0] > {period_register_reg, 2'b11}) |=> active_reg[0];
    endproperty
    a_beyond: assert property (p_beyond) else $error("output cleared beyond period");

    property p_last_idle;
        @(posedge i_clk) disable iff (i_reset)
        (!module_on_reg[CHANNELS-1] && !i_sleep)
            |=> o_pwm[CHANNELS-1] == $past(output_polarity_reg[CHANNELS-1]);
    endproperty
    a_last_idle: assert property (p_last_idle) else $error("last channel not idle");

    property p_rd_idle;
        @(posedge i_clk) disable iff (i_reset)
        !(i_psel && i_penable && !i_pwrite) |-> o_prdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");

endmodule : tbp_pwm

`default_nettype wire

// ---- pkg/tbp_pkg.sv ----
// Package for the dual ten-bit pulse-width modulator block.
// Assumes a 32-bit APB slave with one aligned word per register.
package tbp_pkg;

    // ==========================================================
    // Register map, byte addresses.
    // ==========================================================
    localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_TIMER_COUNT = 8'h08;
    localparam logic [7:0] OFS_MOD0_CONTROL = 8'h10;
    localparam logic [7:0] OFS_MOD0_DUTY_HIGH = 8'h14;
    localparam logic [7:0] OFS_MOD0_DUTY_LOW = 8'h18;
    localparam logic [7:0] OFS_CHANNEL_STRIDE = 8'h10;

    // ==========================================================
    // Field positions.
    // ==========================================================
    localparam int CTL_MODULE_ON_BIT = 7;
    localparam int CTL_LIVE_OUTPUT_BIT = 5;
    localparam int CTL_POLARITY_BIT = 4;
    localparam int DUTY_LOW_MSB = 7;
    localparam int DUTY_LOW_LSB = 6;
    localparam int TCTL_TIMER_RUN_BIT = 2;
    localparam int TCTL_PRESCALE_MSB = 1;

    // ==========================================================
    // Reset values.
    // ==========================================================
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [9:0] RST_DUTY = 10'h000;

    // ==========================================================
    // Timing: oscillator cycles per timer increment at 1:1.
    // ==========================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PER_INCREMENT = 4;
    localparam int SUBCOUNT_W = 6;

endpackage : tbp_pkg

// ---- sim/tbp_load_model.sv ----
// Load model that integrates each modulator pin over one period.
// Assumes the period match pulse marks the first cycle of each period.
`timescale 1ns/1ps
`default_nettype none

module tbp_load_model (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // Pin under load and period marker.
    input wire logic i_pin,
    input wire logic i_frame,
    // Results of the last whole period.
    output logic [15:0] o_high_cnt,
    output logic [15:0] o_period_cnt
);
    logic [15:0] high_reg;
    logic [15:0] span_reg;

    // ==========================================================
    // Count on-time and period length between period markers.
    // ==========================================================
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            high_reg <= 16'h0000;
            span_reg <= 16'h0000;
            o_high_cnt <= 16'h0000;
            o_period_cnt <= 16'h0000;
        end else if (i_frame) begin
            o_high_cnt <= high_reg;
            o_period_cnt <= span_reg;
            high_reg <= {15'h0000, i_pin};
            span_reg <= 16'h0001;
        end else begin
            high_reg <= high_reg + {15'h0000, i_pin};
            span_reg <= span_reg + 16'h0001;
        end
    end
endmodule : tbp_load_model
`default_nettype wire

// ---- sim/ten_bit_pwm_generator_tb.sv ----
// Self-checking bench for the dual pulse-width modulator.
// Assumes a zero-wait APB slave and one load model on each pin.
`timescale 1ns/1ps
`default_nettype none

module ten_bit_pwm_generator_tb;
    import tbp_pkg::*;
    logic i_clk, i_reset, psel, penable, pwrite, sleep, pready, pslverr, match;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1:0] pwm;
    logic [15:0] hi0, hi1, per0, per1;
    logic [32:0] expq[$];
    logic [32:0] e;
    int n_mismatch = 0;
    int n_tests = 0;
    int t_sel[6] = '{0, 1, 2, 3, 0, 0};
    int t_per[6] = '{3, 1, 0, 0, 3, 3};
    int t_d0[6] = '{5, 3, 2, 1, 0, 20};
    int t_d1[6] = '{9, 0, 3, 2, 16, 1};
    int t_en[6] = '{1, 1, 1, 1, 1, 0};

    tbp_pwm #(.CHANNELS(2)) i_tbp_pwm (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_sleep(sleep),
        .o_pwm(pwm), .o_period_match(match));
    tbp_load_model i_tbp_load_model_0 (.i_clk(i_clk), .i_reset(i_reset), .i_pin(pwm[0]),
        .i_frame(match), .o_high_cnt(hi0), .o_period_cnt(per0));
    tbp_load_model i_tbp_load_model_1 (.i_clk(i_clk), .i_reset(i_reset), .i_pin(pwm[1]),
        .i_frame(match), .o_high_cnt(hi1), .o_period_cnt(per1));

    // ==========================================================
    // Clock, checks and bus tasks.
    // ==========================================================
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
        expq.push_back({err, d});
        apb(a, 1'b0, 32'h0000_0000);
    endtask : rd

    task automatic wait_match();
        int k;
        for (k = 0; k < 3000; k++) begin
            @(posedge i_clk);
            if (match === 1'b1) break;
        end
        if (k == 3000) begin
            n_mismatch++;
            $display("unexpected period match: expected pulse, seen none");
        end
        #1;
    endtask : wait_match

    // Stops the timer, rebuilds one row's setup in the safe order, then measures both pins.
    task automatic run_row(input int i);
        int ps, per, a0, a1;
        ps = 1 << (2 * t_sel[i]);
        per = (t_per[i] + 1) * 4 * ps;
        a0 = (t_d0[i] * ps < per) ? t_d0[i] * ps : per;
        a1 = (t_d1[i] * ps < per) ? t_d1[i] * ps : per;
        wr(OFS_TIMER_CONTROL, 32'h0000_0000);
        wr(OFS_TIMER_COUNT, 32'h0000_0000);
        wr(OFS_MOD0_CONTROL, (t_en[i] != 0) ? 32'h0000_0080 : 32'h0000_0000);
        wr(OFS_MOD0_CONTROL + OFS_CHANNEL_STRIDE, 32'h0000_0090);
        wr(OFS_PERIOD, 32'(t_per[i]));
        wr(OFS_MOD0_DUTY_HIGH, 32'(t_d0[i] >> 2));
        wr(OFS_MOD0_DUTY_LOW, 32'((t_d0[i] & 3) << 6));
        wr(OFS_MOD0_DUTY_HIGH + OFS_CHANNEL_STRIDE, 32'(t_d1[i] >> 2));
        wr(OFS_MOD0_DUTY_LOW + OFS_CHANNEL_STRIDE, 32'((t_d1[i] & 3) << 6));
        wr(OFS_TIMER_CONTROL, 32'(4 + t_sel[i]));
        repeat (3) wait_match();
        check("period clocks", 32'(per), {16'h0000, per0});
        check("channel 0 on clocks", (t_en[i] != 0) ? 32'(a0) : 32'h0, {16'h0000, hi0});
        check("channel 1 on clocks", 32'(per - a1), {16'h0000, hi1});
    endtask : run_row

    // ==========================================================
    // Read monitor: compares each read with the oldest note.
    // ==========================================================
    always @(posedge i_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
            e = expq.pop_front();
            check("read data", e[31:0], prdata);
            check("slave error", {31'h0, e[32]}, {31'h0, pslverr});
        end
    end

    initial begin
        repeat (40000) @(posedge i_clk);
        n_mismatch++;
        $display("unexpected run length: expected finish, seen timeout");
        close_out();
    end

    // ==========================================================
    // Test sequence.
    // ==========================================================
    initial begin
        i_reset = 1'b1;
        {psel, penable, pwrite, sleep} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        void'($urandom(32'hB37D));
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        check("idle pins", 32'h0, {30'h0, pwm});
        rd(OFS_MOD0_CONTROL, 32'(RST_CONTROL), 1'b0);
        rd(OFS_MOD0_CONTROL + OFS_CHANNEL_STRIDE, 32'(RST_CONTROL), 1'b0);
        rd(OFS_PERIOD, 32'(RST_PERIOD), 1'b0);
        rd(OFS_TIMER_CONTROL, 32'(RST_TIMER_CONTROL), 1'b0);
        rd(8'h0C, 32'h0000_0000, 1'b1);
        $display("test reset_values done");
        r = $urandom;
        wr(OFS_MOD0_CONTROL, r);
        rd(OFS_MOD0_CONTROL, (r & 32'h90) | (r[4] ? 32'h20 : 32'h0), 1'b0);
        check("disabled pin level", {31'h0, r[4]}, {31'h0, pwm[0]});
        r = $urandom;
        wr(OFS_MOD0_DUTY_HIGH, r);
        wr(OFS_MOD0_DUTY_LOW, r);
        wr(8'h0C, r);
        rd(OFS_MOD0_DUTY_HIGH, r & 32'hFF, 1'b0);
        rd(OFS_MOD0_DUTY_LOW, r & 32'hC0, 1'b0);
        rd(8'h0C, 32'h0000_0000, 1'b1);
        $display("test register_fields done");
        for (int i = 0; i < 6; i++) run_row(i);
        $display("test waveforms done");
        run_row(0);
        @(posedge i_clk);
        sleep <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        r = {30'h0, pwm};
        repeat (40) begin
            @(posedge i_clk);
            #1;
            check("frozen pins", r, {30'h0, pwm});
            check("match in sleep", 32'h0, {31'h0, match});
        end
        @(posedge i_clk);
        sleep <= 1'b0;
        repeat (2) wait_match();
        check("period after wake", 32'h10, {16'h0000, per0});
        $display("test sleep done");
        repeat (4) @(posedge i_clk);
        close_out();
    end
endmodule : ten_bit_pwm_generator_tb
`default_nettype wire
